// file: gpio_led_map.vh
`ifndef GPIO_LED_MAP_VH
`define GPIO_LED_MAP_VH

// Register byte addresses
`define LAMP_CONFIG_ADDR 9'h1bc
`define PIN_CONFIG_ADDR 9'h1e0
`define PIN_DATA_DIR_ADDR 9'h1e4
`define PIN_IRQ_STATUS_ENABLE_ADDR 9'h1e8
`define POWER_MGMT_CONTROL_ADDR 9'h084
`define GLOBAL_IRQ_STATUS_ADDR 9'h058

// Field positions (low bit of each three-bit field; global disable and event are single bits)
`define LAMP_ENABLE_POS 0
`define LAMP_FUNCTION_POS 8
`define PIN_BUFFER_TYPE_POS 16
`define PIN_IRQ_POLARITY_POS 24
`define PIN_DATA_POS 0
`define PIN_DIRECTION_POS 8
`define PIN_IRQ_STATUS_POS 0
`define PIN_IRQ_ENABLE_POS 16
`define LAMP_GLOBAL_DISABLE_POS 0
`define GPIO_EVENT_POS 12

// Reset values of software fields
`define PIN_DIRECTION_RESET 3'h0
`define PIN_IRQ_ENABLE_RESET 3'h0
`define PIN_IRQ_POLARITY_RESET 3'h0
`define PIN_BUFFER_TYPE_RESET 3'h0
`define PIN_DATA_RESET 3'h0
`define PIN_IRQ_STATUS_RESET 3'h0
`define LAMP_GLOBAL_DISABLE_RESET 1'h0

// Timing
`define CLK_PERIOD_PS 25000
`define CLK_FREQ_KHZ 40000
`define IRQ_MIN_NS 40
`define IRQ_FILTER_CYCLES ((`IRQ_MIN_NS * 1000) / `CLK_PERIOD_PS + 1)
`define LAMP_PULSE_MS 80
`define LAMP_PULSE_CYCLES (`LAMP_PULSE_MS * `CLK_FREQ_KHZ)

// Lamp function codes
`define LAMP_FUN_0 3'h0
`define LAMP_FUN_1 3'h1
`define LAMP_FUN_2 3'h2
`define LAMP_FUN_3 3'h3
`define LAMP_FUN_4 3'h4

// Indication kinds
`define IND_OFF 4'h0
`define IND_LINK_ACT 4'h1
`define IND_FDX_COL 4'h2
`define IND_SPEED 4'h3
`define IND_L100_ACT 4'h4
`define IND_L10_ACT 4'h5
`define IND_ACT 4'h6
`define IND_LINK 4'h7
`define IND_L10 4'h8
`define IND_L100 4'h9

`endif

// file: lamp_pulse_timer.v
`timescale 1ns/1ps
`include "gpio_led_map.vh"
// One pulse of a fixed length, then a guard time of the same length
module lamp_pulse_timer #(
    parameter integer PULSE_CYCLES = `LAMP_PULSE_CYCLES
) (
    input wire mclk,
    input wire rst,
    input wire trigger,
    output wire pulse
);
    localparam [2:0] IDLE = 3'h1;
    localparam [2:0] ON = 3'h2;
    localparam [2:0] GUARD = 3'h4;
    localparam integer LAST_FULL = PULSE_CYCLES - 1;
    localparam [21:0] LAST = LAST_FULL[21:0];

    reg [2:0] state;
    reg [21:0] count;

    assign pulse = state[1];

    always @(posedge mclk) begin
        if (rst) begin
            state <= IDLE;
            count <= 22'h0;
        end else begin
            case (state)
                IDLE: begin
                    count <= 22'h0;
                    if (trigger) begin
                        state <= ON;
                    end
                end
                ON: begin
                    if (count == LAST) begin
                        count <= 22'h0;
                        state <= GUARD;
                    end else begin
                        count <= count + 22'h1;
                    end
                end
                GUARD: begin
                    // New traffic is only looked at once the guard has run out
                    if (count == LAST) begin
                        count <= 22'h0;
                        state <= IDLE;
                    end else begin
                        count <= count + 22'h1;
                    end
                end
                default: begin
                    state <= IDLE;
                    count <= 22'h0;
                end
            endcase
        end
    end
endmodule

// file: gpio_led_pin_controller.v
`timescale 1ns/1ps
`include "gpio_led_map.vh"
// Operation
// - Reset clears every pin direction bit, so all pins are inputs.
// - Reset clears every pin interrupt enable bit.
// - Reset clears every polarity bit, so interrupts trigger on low level.
// - An output pin uses its buffer-type bit to pick push-pull or open-drain.
// - Open-drain output pulls low for data 0, leaves pin undriven for 1.
// - Push-pull output drives the pin to its data bit.
// - Reading data of an input pin returns the pin's present level.
// - GPIO output pins have input buffer off; pull-up normally on.
// - Each pin has a readable interrupt status bit and its own enable bit.
// - Enabled pin interrupts merge into one request, seen as a global event bit.
// - Interrupts are level sensitive, recognised only after more than 40 ns.
// - Polarity set: high level sets status; clear: low level sets it.
// - Lamp enable makes the pin an LED; input buffer and pull-up off.
// - Lamp enable, function code and polarity defaults come from straps.
// - Global lamp disable leaves LED pins undriven or inactive.
// - Function codes 000b to 011b pick indications per the code table.
// - Code 100b: activity, 10-link, 100-link; 101b to 111b reserved.
// - Active LED drives opposite of latched strap; inactive LED is undriven.
// - Activity pulses 80 ms on traffic, then inactive 80 ms; off without link.
// - Link/activity active on link, pulses inactive 80 ms, then active 80 ms.
module gpio_led_pin_controller #(
    parameter integer PULSE_CYCLES = `LAMP_PULSE_CYCLES
) (
    input wire mclk,
    input wire rst,
    input wire [8:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    output reg [31:0] readdata,
    output wire waitrequest,
    input wire [2:0] pin_in,
    output reg [2:0] pin_out,
    output reg [2:0] pin_oe,
    output reg [2:0] pin_pullup_en,
    output reg [2:0] pin_inbuf_en,
    input wire [2:0] lamp_enable_straps,
    input wire [2:0] lamp_function_straps,
    input wire [2:0] lamp_polarity_straps,
    input wire link_up,
    input wire speed_100,
    input wire full_duplex,
    input wire collision,
    input wire traffic,
    output reg gpio_irq_request
);
    localparam integer IRQ_FILTER = `IRQ_FILTER_CYCLES;
    localparam [2:0] IRQ_CYCLES = IRQ_FILTER[2:0];

    ////////////////////////////////////////////////////////////////////////
    // Functions

    function hit;
        input [8:0] addr;
        input [8:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    // Which indication a pin shows for a function code
    function [3:0] indication;
        input [2:0] code;
        input [1:0] pin;
        begin
            indication = `IND_OFF;
            case (code)
                `LAMP_FUN_0: begin
                    indication = (pin == 2'h2) ? `IND_LINK_ACT : (pin == 2'h1) ? `IND_FDX_COL : `IND_SPEED;
                end
                `LAMP_FUN_1: begin
                    indication = (pin == 2'h2) ? `IND_L100_ACT : (pin == 2'h1) ? `IND_FDX_COL : `IND_L10_ACT;
                end
                `LAMP_FUN_2: begin
                    indication = (pin == 2'h2) ? `IND_ACT : (pin == 2'h1) ? `IND_LINK : `IND_SPEED;
                end
                `LAMP_FUN_3: begin
                    indication = (pin == 2'h2) ? `IND_ACT : (pin == 2'h1) ? `IND_LINK : `IND_FDX_COL;
                end
                `LAMP_FUN_4: begin
                    indication = (pin == 2'h2) ? `IND_ACT : (pin == 2'h1) ? `IND_L10 : `IND_L100;
                end
                default: begin
                    // Reserved codes leave the lamp dark
                    indication = `IND_OFF;
                end
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin and strap synchronisers

    reg [2:0] pin_meta;
    reg [2:0] pin_sync;
    reg [8:0] strap_meta;
    reg [8:0] strap_sync;

    always @(posedge mclk) begin
        pin_meta <= pin_in;
        pin_sync <= pin_meta;
        strap_meta <= {lamp_polarity_straps, lamp_function_straps, lamp_enable_straps};
        strap_sync <= strap_meta;
    end

    ////////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait state on every access

    reg ack;
    wire request = read | write;
    wire take = request & ack;

    assign waitrequest = request & ~ack;

    always @(posedge mclk) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= request & ~ack;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    reg [2:0] lamp_enable_bits;
    reg [2:0] lamp_function_code;
    reg [2:0] lamp_polarity;
    reg lamp_global_disable;
    reg [2:0] pin_direction_bits;
    reg [2:0] pin_buffer_type_bits;
    reg [2:0] pin_data_bits;
    reg [2:0] pin_irq_polarity_bits;
    reg [2:0] pin_irq_enable;
    reg [2:0] pin_irq_status;
    reg [2:0] irq_level;

    wire wr = take & write;
    wire wr_lamp0 = wr & hit(address, `LAMP_CONFIG_ADDR) & byteenable[0];
    wire wr_lamp1 = wr & hit(address, `LAMP_CONFIG_ADDR) & byteenable[1];
    wire wr_cfg2 = wr & hit(address, `PIN_CONFIG_ADDR) & byteenable[2];
    wire wr_cfg3 = wr & hit(address, `PIN_CONFIG_ADDR) & byteenable[3];
    wire wr_dd0 = wr & hit(address, `PIN_DATA_DIR_ADDR) & byteenable[0];
    wire wr_dd1 = wr & hit(address, `PIN_DATA_DIR_ADDR) & byteenable[1];
    wire wr_ise0 = wr & hit(address, `PIN_IRQ_STATUS_ENABLE_ADDR) & byteenable[0];
    wire wr_ise2 = wr & hit(address, `PIN_IRQ_STATUS_ENABLE_ADDR) & byteenable[2];
    wire wr_pm0 = wr & hit(address, `POWER_MGMT_CONTROL_ADDR) & byteenable[0];

    wire [2:0] clear_req = wr_ise0 ? writedata[`PIN_IRQ_STATUS_POS +: 3] : 3'h0;

    always @(posedge mclk) begin
        if (rst) begin
            // Straps are reloaded each reset cycle, so reset must outlast the synchroniser
            lamp_enable_bits <= strap_sync[2:0];
            lamp_function_code <= strap_sync[5:3];
            lamp_polarity <= strap_sync[8:6];
            lamp_global_disable <= `LAMP_GLOBAL_DISABLE_RESET;
            pin_direction_bits <= `PIN_DIRECTION_RESET;
            pin_irq_enable <= `PIN_IRQ_ENABLE_RESET;
            pin_irq_polarity_bits <= `PIN_IRQ_POLARITY_RESET;
            pin_buffer_type_bits <= `PIN_BUFFER_TYPE_RESET;
            pin_data_bits <= `PIN_DATA_RESET;
            pin_irq_status <= `PIN_IRQ_STATUS_RESET;
        end else begin
            if (wr_lamp0) begin
                lamp_enable_bits <= writedata[`LAMP_ENABLE_POS +: 3];
            end
            if (wr_lamp1) begin
                lamp_function_code <= writedata[`LAMP_FUNCTION_POS +: 3];
            end
            if (wr_cfg2) begin
                pin_buffer_type_bits <= writedata[`PIN_BUFFER_TYPE_POS +: 3];
            end
            if (wr_cfg3) begin
                pin_irq_polarity_bits <= writedata[`PIN_IRQ_POLARITY_POS +: 3];
            end
            if (wr_dd0) begin
                pin_data_bits <= writedata[`PIN_DATA_POS +: 3];
            end
            if (wr_dd1) begin
                pin_direction_bits <= writedata[`PIN_DIRECTION_POS +: 3];
            end
            if (wr_ise2) begin
                pin_irq_enable <= writedata[`PIN_IRQ_ENABLE_POS +: 3];
            end
            if (wr_pm0) begin
                lamp_global_disable <= writedata[`LAMP_GLOBAL_DISABLE_POS];
            end
            // A level still present sets the bit again, so it wins over a clear
            pin_irq_status <= (pin_irq_status & ~clear_req) | irq_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt level filter, per pin

    reg [2:0] filt_count [0:2];
    wire gpio_event = |(pin_irq_status & pin_irq_enable);

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : irq_filter
            wire input_mode = ~lamp_enable_bits[g] & ~pin_direction_bits[g];
            wire asserted = input_mode & (pin_sync[g] == pin_irq_polarity_bits[g]);

            always @(posedge mclk) begin
                if (rst) begin
                    filt_count[g] <= 3'h0;
                    irq_level[g] <= 1'b0;
                end else begin
                    if (!asserted) begin
                        filt_count[g] <= 3'h0;
                    end else if (filt_count[g] != IRQ_CYCLES) begin
                        filt_count[g] <= filt_count[g] + 3'h1;
                    end
                    // Only a level held past the minimum width counts
                    irq_level[g] <= asserted & (filt_count[g] >= IRQ_CYCLES - 3'h1);
                end
            end
        end
    endgenerate

    always @(posedge mclk) begin
        if (rst) begin
            gpio_irq_request <= 1'b0;
        end else begin
            gpio_irq_request <= gpio_event;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data

    wire [2:0] data_view;
    generate
        for (g = 0; g < 3; g = g + 1) begin : data_read
            // Inputs show the pin; outputs and lamps show the stored bit
            assign data_view[g] = (pin_direction_bits[g] | lamp_enable_bits[g]) ? pin_data_bits[g] : pin_sync[g];
        end
    endgenerate

    reg [31:0] next_readdata;

    always @* begin
        next_readdata = 32'h0;
        if (hit(address, `LAMP_CONFIG_ADDR)) begin
            next_readdata[`LAMP_ENABLE_POS +: 3] = lamp_enable_bits;
            next_readdata[`LAMP_FUNCTION_POS +: 3] = lamp_function_code;
        end else if (hit(address, `PIN_CONFIG_ADDR)) begin
            next_readdata[`PIN_BUFFER_TYPE_POS +: 3] = pin_buffer_type_bits;
            next_readdata[`PIN_IRQ_POLARITY_POS +: 3] = pin_irq_polarity_bits;
        end else if (hit(address, `PIN_DATA_DIR_ADDR)) begin
            next_readdata[`PIN_DATA_POS +: 3] = data_view;
            next_readdata[`PIN_DIRECTION_POS +: 3] = pin_direction_bits;
        end else if (hit(address, `PIN_IRQ_STATUS_ENABLE_ADDR)) begin
            next_readdata[`PIN_IRQ_STATUS_POS +: 3] = pin_irq_status;
            next_readdata[`PIN_IRQ_ENABLE_POS +: 3] = pin_irq_enable;
        end else if (hit(address, `POWER_MGMT_CONTROL_ADDR)) begin
            next_readdata[`LAMP_GLOBAL_DISABLE_POS] = lamp_global_disable;
        end else if (hit(address, `GLOBAL_IRQ_STATUS_ADDR)) begin
            next_readdata[`GPIO_EVENT_POS] = gpio_event;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            readdata <= 32'h0;
        end else if (read & ~ack) begin
            readdata <= next_readdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lamp timers: activity and collision

    wire act_pulse;
    wire col_pulse;

    lamp_pulse_timer #(
        .PULSE_CYCLES(PULSE_CYCLES)
    ) act_timer (
        .mclk(mclk),
        .rst(rst),
        .trigger(traffic & link_up),
        .pulse(act_pulse)
    );

    lamp_pulse_timer #(
        .PULSE_CYCLES(PULSE_CYCLES)
    ) col_timer (
        .mclk(mclk),
        .rst(rst),
        .trigger(collision & link_up & ~full_duplex),
        .pulse(col_pulse)
    );

    reg [2:0] lit;

    always @* begin : lamp_levels
        integer i;
        reg [3:0] kind;
        lit = 3'h0;
        kind = `IND_OFF;
        for (i = 0; i < 3; i = i + 1) begin
            kind = indication(lamp_function_code, i[1:0]);
            case (kind)
                `IND_LINK_ACT: lit[i] = link_up & ~act_pulse;
                `IND_FDX_COL: lit[i] = link_up & (full_duplex | col_pulse);
                `IND_SPEED: lit[i] = link_up & speed_100;
                `IND_L100_ACT: lit[i] = link_up & speed_100 & ~act_pulse;
                `IND_L10_ACT: lit[i] = link_up & ~speed_100 & ~act_pulse;
                `IND_ACT: lit[i] = link_up & act_pulse;
                `IND_LINK: lit[i] = link_up;
                `IND_L10: lit[i] = link_up & ~speed_100;
                `IND_L100: lit[i] = link_up & speed_100;
                default: lit[i] = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers

    generate
        for (g = 0; g < 3; g = g + 1) begin : pin_drive
            always @(posedge mclk) begin
                if (rst) begin
                    pin_out[g] <= 1'b0;
                    pin_oe[g] <= 1'b0;
                    pin_pullup_en[g] <= 1'b1;
                    pin_inbuf_en[g] <= 1'b1;
                end else if (lamp_enable_bits[g]) begin
                    // Lamp mode takes the pin over from the GPIO settings
                    pin_out[g] <= ~lamp_polarity[g];
                    pin_oe[g] <= lit[g] & ~lamp_global_disable;
                    pin_pullup_en[g] <= 1'b0;
                    pin_inbuf_en[g] <= 1'b0;
                end else if (pin_direction_bits[g]) begin
                    if (pin_buffer_type_bits[g]) begin
                        pin_out[g] <= pin_data_bits[g];
                        pin_oe[g] <= 1'b1;
                    end else begin
                        pin_out[g] <= 1'b0;
                        pin_oe[g] <= ~pin_data_bits[g];
                    end
                    pin_pullup_en[g] <= 1'b1;
                    pin_inbuf_en[g] <= 1'b0;
                end else begin
                    pin_out[g] <= 1'b0;
                    pin_oe[g] <= 1'b0;
                    pin_pullup_en[g] <= 1'b1;
                    pin_inbuf_en[g] <= 1'b1;
                end
            end
        end
    endgenerate
endmodule

// file: gpio_led_pin_controller_sva.sv
`timescale 1ns/1ps
module gpio_led_pin_controller_sva (
    input wire mclk,
    input wire rst,
    input wire [8:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    input wire [31:0] readdata,
    input wire waitrequest,
    input wire [2:0] pin_out,
    input wire [2:0] pin_oe,
    input wire [2:0] pin_pullup_en,
    input wire [2:0] pin_inbuf_en,
    input wire [2:0] lamp_polarity_straps,
    input wire gpio_irq_request
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Full-word writes only, so a field decode cannot be fooled by a masked lane
    wire wr_done = write && !waitrequest && byteenable == 4'hf;
    ////////////////////////////////////////////////////////////////////////////////
    property p_rst_out; $fell(rst) |-> pin_oe == 3'h0 && !gpio_irq_request; endproperty
    a_rst_out: assert property (p_rst_out)
        else $error("pin driven or request raised at reset release");
    property p_ack_first; $rose(read || write) |-> waitrequest; endproperty
    a_ack_first: assert property (p_ack_first)
        else $error("access answered in its first cycle");
    property p_ack_second; (read || write) && waitrequest |=> !waitrequest; endproperty
    a_ack_second: assert property (p_ack_second)
        else $error("access not answered in its second cycle");
    property p_lamp_level; (pin_oe & ~pin_pullup_en & (pin_out ^ ~lamp_polarity_straps)) == 3'h0; endproperty
    a_lamp_level: assert property (p_lamp_level)
        else $error("lamp driven to the strap level");
    property p_inbuf; (pin_oe & pin_inbuf_en) == 3'h0; endproperty
    a_inbuf: assert property (p_inbuf)
        else $error("input buffer on while pin driven");
    property p_lamp_pull; (~pin_pullup_en & pin_inbuf_en) == 3'h0; endproperty
    a_lamp_pull: assert property (p_lamp_pull)
        else $error("input buffer on without pull-up");
    property p_dir_in; wr_done && address == 9'h1e4 && writedata[10:8] == 3'h0 |-> ##[1:2] (pin_oe & pin_pullup_en) == 3'h0; endproperty
    a_dir_in: assert property (p_dir_in)
        else $error("gpio pin still driven after direction cleared");
    property p_disable; wr_done && address == 9'h084 && writedata[0] |-> ##2 ((pin_oe & ~pin_pullup_en) == 3'h0) [*3]; endproperty
    a_disable: assert property (p_disable)
        else $error("lamp driven while globally disabled");
    property p_event; read && !waitrequest && address == 9'h058 |-> readdata[12] == gpio_irq_request || readdata[12] == $past(gpio_irq_request); endproperty
    a_event: assert property (p_event)
        else $error("global event bit differs from request");
endmodule

bind gpio_led_pin_controller gpio_led_pin_controller_sva checker_i (.mclk(mclk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .pin_inbuf_en(pin_inbuf_en), .lamp_polarity_straps(lamp_polarity_straps), .gpio_irq_request(gpio_irq_request));

// file: board_pins.sv
`timescale 1ns/1ps
module board_pins (
    input wire mclk,
    input wire [2:0] pin_out,
    input wire [2:0] pin_oe,
    input wire [2:0] pin_pullup_en,
    input wire [2:0] ext_val,
    input wire [2:0] ext_oe,
    output logic [2:0] pin_in
);
    logic flip = 1'b0;
    always @(posedge mclk) flip <= ~flip;
    // A floating pin keeps moving so no stale level can pass for a real one
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (ext_oe[i]) pin_in[i] = ext_val[i];
            else if (pin_pullup_en[i]) pin_in[i] = 1'b1;
            else pin_in[i] = flip;
        end
    end
endmodule

// file: gpio_led_pin_controller_tb_top.sv
`timescale 1ns/1ps
module gpio_led_pin_controller_tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [8:0] address = 9'h000;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [2:0] ext_val = 3'b010;
    logic [2:0] ext_oe = 3'h0;
    logic link_up = 1'b1;
    logic speed_100 = 1'b1;
    logic full_duplex = 1'b1;
    logic traffic = 1'b0;
    logic collision = 1'b0;
    wire [31:0] readdata;
    wire waitrequest;
    wire gpio_irq_request;
    wire [2:0] pin_in, pin_out, pin_oe, pin_pullup_en, pin_inbuf_en;
    int mismatches = 0;
    int compares = 0;
    logic [31:0] q;
    logic [2:0] e;
    logic seen;
    always #12.5 mclk = ~mclk;
    // Short pulse length keeps the lamp timing checks to a few dozen cycles
    gpio_led_pin_controller #(.PULSE_CYCLES(8)) dut (.mclk(mclk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
        .pin_inbuf_en(pin_inbuf_en), .lamp_enable_straps(3'h0), .lamp_function_straps(3'h3),
        .lamp_polarity_straps(3'b101), .link_up(link_up), .speed_100(speed_100), .full_duplex(full_duplex),
        .collision(collision), .traffic(traffic), .gpio_irq_request(gpio_irq_request));
    board_pins bp (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
        .ext_val(ext_val), .ext_oe(ext_oe), .pin_in(pin_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic acc(input logic w, input logic [8:0] a, input logic [31:0] d);
        @(posedge mclk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        // Request, waitrequest and read data are all judged at the rising edge
        do @(posedge mclk); while (waitrequest);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    function automatic logic [2:0] act(input logic [2:0] c, input logic v);
        case (c)
            3'h0: act = {1'b1, v, v};
            3'h1: act = {v, v, ~v};
            3'h2: act = {2'b01, v};
            3'h3: act = {2'b01, v};
            3'h4: act = {1'b0, ~v, v};
            default: act = 3'h0;
        endcase
    endfunction
    task automatic stop_test;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // The whole sequence needs about 400 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        stop_test();
    end
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        acc(0, 9'h1e4, 0); chk("direction", 0, q[10:8]);
        acc(0, 9'h1e8, 0); chk("irq enable", 0, q[18:16]);
        acc(0, 9'h1e0, 0); chk("polarity", 0, q[26:24]);
        acc(0, 9'h1bc, 0); chk("lamp config", 32'h300, q[10:0]);
        acc(0, 9'h100, 0); chk("unmapped", 0, q);
        ext_oe <= 3'b111;
        wt(5);
        acc(0, 9'h1e4, 0); chk("input data", 3'b010, q[2:0]);
        chk("input buffers", 3'b111, pin_inbuf_en);
        ext_oe <= 3'h0;
        acc(1, 9'h1e0, 32'h70000);
        acc(1, 9'h1e4, 32'h705);
        wt(2);
        chk("push-pull oe", 3'b111, pin_oe);
        chk("push-pull out", 3'b101, pin_out);
        chk("output buffers", {3'b111, 3'h0}, {pin_pullup_en, pin_inbuf_en});
        acc(1, 9'h1e0, 0);
        wt(2);
        chk("open-drain oe", 3'b010, pin_oe);
        chk("open-drain out", 0, pin_out & pin_oe);
        // Interrupts, pull-ups hold idle pins high
        acc(1, 9'h1e4, 0);
        // A pin released from driving low may latch a status bit; let it settle before clearing
        wt(4);
        acc(1, 9'h1e8, 32'h7);
        acc(1, 9'h1e8, 32'h30000);
        @(posedge mclk);
        ext_oe <= 3'b001;
        @(posedge mclk);
        ext_oe <= 3'h0;
        wt(8);
        acc(0, 9'h1e8, 0); chk("glitch status", 32'h30000, q);
        chk("glitch request", 0, gpio_irq_request);
        ext_oe <= 3'b001;
        wt(8);
        acc(0, 9'h1e8, 0); chk("low status", 32'h30001, q);
        chk("request", 1, gpio_irq_request);
        acc(0, 9'h058, 0); chk("global event", 1, q[12]);
        acc(1, 9'h1e8, 32'h30001);
        wt(2);
        acc(0, 9'h1e8, 0); chk("clear while low", 1, q[2:0]);
        ext_oe <= 3'h0;
        wt(8);
        acc(1, 9'h1e8, 32'h30000);
        acc(0, 9'h1e8, 0); chk("write zero", 1, q[2:0]);
        acc(1, 9'h1e8, 32'h30001);
        wt(2);
        acc(0, 9'h1e8, 0); chk("cleared", 0, q[2:0]);
        chk("request gone", 0, gpio_irq_request);
        acc(1, 9'h1e0, 32'h2000000);
        wt(8);
        acc(0, 9'h1e8, 0); chk("high status", 3'b010, q[2:0]);
        acc(1, 9'h1e8, 32'h10000);
        wt(2);
        chk("masked request", 0, gpio_irq_request);
        // Lamps over push-pull gpio outputs driving 0
        acc(1, 9'h1e0, 32'h2070000);
        acc(1, 9'h1e4, 32'h700);
        for (int v = 0; v < 2; v++) begin
            speed_100 <= v[0];
            full_duplex <= v[0];
            for (int c = 0; c < 8; c++) begin
                acc(1, 9'h1bc, {21'h0, c[2:0], 8'h07});
                wt(4);
                e = act(c[2:0], v[0]);
                chk("lamp oe", e, pin_oe);
                chk("lamp out", ~3'b101 & e, pin_out & e);
                chk("lamp buffers", 0, pin_pullup_en | pin_inbuf_en);
            end
        end
        for (int k = 0; k < 2; k++) begin
            acc(1, 9'h1bc, k ? 32'h207 : 32'h7);
            wt(4);
            chk("activity idle", k ? 0 : 1, pin_oe[2]);
            @(posedge mclk);
            traffic <= 1'b1;
            @(posedge mclk);
            traffic <= 1'b0;
            seen = 1'b0;
            repeat (6) begin
                @(negedge mclk);
                if (pin_oe[2] === k[0]) seen = 1'b1;
            end
            chk("activity pulse", 1, seen);
            repeat (40) @(negedge mclk);
            chk("activity end", k ? 0 : 1, pin_oe[2]);
        end
        acc(1, 9'h1bc, 32'h7);
        wt(4);
        chk("lamps on", 3'b111, pin_oe);
        @(posedge mclk);
        full_duplex <= 1'b0;
        wt(2);
        chk("half duplex", 3'b101, pin_oe);
        @(posedge mclk);
        collision <= 1'b1;
        @(posedge mclk);
        collision <= 1'b0;
        wt(2);
        chk("collision", 3'b111, pin_oe);
        acc(1, 9'h084, 1);
        wt(3);
        chk("lamps disabled", 0, pin_oe);
        acc(1, 9'h084, 0);
        link_up <= 1'b0;
        wt(4);
        chk("no link", 0, pin_oe);
        stop_test();
    end
endmodule
